// ### src/pfe_params.svh
// offsets, field positions, reset values and counts for the row-erase sequencer
// assumes a 32-bit AHB-Lite bus with word-aligned registers
//
// How it works
// - erase clears exactly one 64-word row
// - no single-word erase exists
// - pointer bits 21:6 select row, 5:0 ignored
// - erase-select chooses erase, otherwise a write
// - cpu stalled until erase timer ends
// - protected row: start cleared, error, no erase
// - completion clears start, sets done, irq if enabled
// - latches and program enable stay unchanged
// - aborted operation sets the error flag
// - start on invalid address sets error
`ifndef PFE_PARAMS_SVH
`define PFE_PARAMS_SVH

// register byte offsets
`define PFE_OFF_CTRL 8'h00
`define PFE_OFF_PTR 8'h04
`define PFE_OFF_UNLOCK 8'h08
`define PFE_OFF_STAT 8'h0C
`define PFE_OFF_MASK 8'h10
`define PFE_OFF_PROT 8'h14

// memory_control_one field positions
`define PFE_CTRL_REG_HI 7
`define PFE_CTRL_REG_LO 6
`define PFE_CTRL_ERASE 4
`define PFE_CTRL_ERR 3
`define PFE_CTRL_WEN 2
`define PFE_CTRL_START 1

// interrupt status / mask bit positions
`define PFE_IRQ_DONE 0
`define PFE_IRQ_ERR 1

// region code that selects the program flash array
`define PFE_REGION_PFA 2'h2

// unlock key sequence
`define PFE_KEY_ONE 8'h55
`define PFE_KEY_TWO 8'hAA

// table pointer layout
`define PFE_PTR_W 22
`define PFE_ROW_LO 6
`define PFE_ROW_W 16

// reset values
`define PFE_CTRL_RST 8'h00
`define PFE_MASK_RST 2'h0
`define PFE_PROT_RST 16'h0000

// default erase timer length in system cycles and array size in rows
`define PFE_ERASE_CYCLES 2000
`define PFE_ROWS 256

`endif

// ### src/pfe_pkg.sv
// types shared by the row-erase sequencer
// assumes pfe_params.svh holds the numeric constants
package pfe_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    PFE_IDLE,
    PFE_BUSY
  } pfe_state_e;

  // kind of long write in progress
  typedef enum logic {
    PFE_OP_WRITE,
    PFE_OP_ERASE
  } pfe_op_e;

  typedef logic [15:0] pfe_row_t;
endpackage : pfe_pkg

// ### src/pfe_timer.sv
// self-timed long write counter for the row-erase sequencer
// assumes start and abort are single-cycle pulses on the system clock
`timescale 1ns/10ps
`default_nettype none
module pfe_timer #(
  parameter int CYCLES = 2000
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic i_abort,
  output logic o_busy,
  output logic o_done
);
  localparam int CW = $clog2(CYCLES + 1);

  // refuse a zero-length timer
  generate
    if (CYCLES < 1) begin : g_bad
      $error("pfe_timer: CYCLES must be at least 1");
    end
  endgenerate

  logic [CW-1:0] count_r; // cycles left
  logic busy_r; // long write running
  logic last; // final counted cycle of the long write

  // ---------------------------------------------------------
  // countdown
  // ---------------------------------------------------------
  // loads on start, ends by expiry or abort
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      count_r <= '0;
      busy_r <= 1'b0;
    end else begin
      if (i_start && !busy_r) begin
        count_r <= CW'(CYCLES);
        busy_r <= 1'b1;
      end else if (busy_r && i_abort) begin
        busy_r <= 1'b0; // cut short, no done
      end else if (busy_r) begin
        if (last) begin
          busy_r <= 1'b0;
        end
        count_r <= count_r - CW'(1);
      end
    end
  end

  // done marks the final busy cycle, so whoever waits on it drops
  // its own busy state at the same edge as the counter does
  assign last = busy_r && (count_r == CW'(1));
  assign o_busy = busy_r;
  assign o_done = last && !i_abort;

  // busy lasts exactly CYCLES cycles when not aborted
  logic [CW-1:0] run_r; // helper: cycles busy so far
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !busy_r) run_r <= '0;
    else run_r <= run_r + CW'(1);
  end
  timer_length_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_done |-> (run_r == CW'(CYCLES - 1)))
    else $error("long write ended at the wrong count");
endmodule : pfe_timer
`default_nettype wire

// ### src/pfe_top.sv
// row-erase sequencer for the program flash array with an AHB-Lite register slave
// assumes one master, single word transfers, and the array on the system clock
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "pfe_params.svh"
module pfe_top #(
  parameter int ERASE_CYCLES = `PFE_ERASE_CYCLES,
  parameter int ROWS = `PFE_ROWS
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // array side
  input wire logic i_flash_abort,
  output logic o_flash_erase,
  output logic o_flash_write,
  output pfe_pkg::pfe_row_t o_flash_row,
  output logic o_cpu_stall,
  output logic o_irq
);
  import pfe_pkg::*;

  // refuse sizes the logic cannot serve
  generate
    if (ROWS < 1 || ROWS > 65536) begin : g_bad_rows
      $error("pfe_top: ROWS out of range");
    end
    if (ERASE_CYCLES < 1) begin : g_bad_cycles
      $error("pfe_top: ERASE_CYCLES must be at least 1");
    end
  endgenerate

  // ---------------------------------------------------------
  // ahb address phase capture
  // ---------------------------------------------------------
  logic wr_pend_r; // write data phase pending
  logic [7:0] wr_addr_r; // captured write offset
  logic [31:0] rdata_r; // read data register

  logic addr_ok; // valid transfer this cycle
  assign addr_ok = i_hsel && i_hready && i_htrans[1];

  // zero wait states, always okay
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && i_hwrite;
      if (addr_ok) wr_addr_r <= i_haddr[7:0];
    end
  end

  // register map, one word each, unused high bits read zero:
  //   0x00 control fields, 0x04 table pointer, 0x08 unlock keys,
  //   0x0C event status (write one to clear), 0x10 interrupt mask,
  //   0x14 protection boundary in rows
  // a write lands at the end of its data phase, so the strobes below
  // only ever qualify the data that stands on hwdata in that cycle
  // write strobes, valid during the data phase
  logic wr_ctrl, wr_ptr, wr_unlock, wr_stat, wr_mask, wr_prot;
  assign wr_ctrl = wr_pend_r && (wr_addr_r == `PFE_OFF_CTRL);
  assign wr_ptr = wr_pend_r && (wr_addr_r == `PFE_OFF_PTR);
  assign wr_unlock = wr_pend_r && (wr_addr_r == `PFE_OFF_UNLOCK);
  assign wr_stat = wr_pend_r && (wr_addr_r == `PFE_OFF_STAT);
  assign wr_mask = wr_pend_r && (wr_addr_r == `PFE_OFF_MASK);
  assign wr_prot = wr_pend_r && (wr_addr_r == `PFE_OFF_PROT);

  // ---------------------------------------------------------
  // software registers
  // ---------------------------------------------------------
  logic [1:0] region_r; // region select
  logic erase_sel_r; // erase instead of write
  logic program_enable_r; // write enable
  logic program_error_r; // error flag
  logic [`PFE_PTR_W-1:0] table_pointer_r; // table pointer
  logic [1:0] irq_mask_r; // bit0 is memory_done_irq_enable
  logic [1:0] irq_stat_r; // bit0 memory_done_flag, bit1 error
  logic [15:0] prot_rows_r; // rows below this are protected
  logic key_one_r; // first key seen
  logic armed_r; // unlock complete

  // sequencer state
  pfe_state_e state_r;
  pfe_op_e op_r;
  pfe_row_t row_r;
  logic timer_busy, timer_done;

  // a start is judged in this order: region and array bounds, then
  // protection, then unlock and program enable; the error paths do not
  // need the unlock, so a refused address or protected row flags an error even when locked
  // start request decoding
  logic start_req; // start bit written to one
  pfe_row_t req_row; // row from pointer bits 21:6
  logic req_invalid; // outside region or array
  logic req_protected; // inside protected rows
  logic launch; // accepted long write
  logic abort_evt; // running op cut short
  logic err_evt; // any error event

  assign start_req = wr_ctrl && i_hwdata[`PFE_CTRL_START] && (state_r == PFE_IDLE);
  assign req_row = table_pointer_r[`PFE_ROW_LO +: `PFE_ROW_W];
  assign req_invalid = (i_hwdata[`PFE_CTRL_REG_HI:`PFE_CTRL_REG_LO] != `PFE_REGION_PFA)
                       || (32'(req_row) >= 32'(ROWS));
  assign req_protected = (req_row < prot_rows_r);
  // launch needs unlock and program enable
  assign launch = start_req && !req_invalid && !req_protected
                  && armed_r && i_hwdata[`PFE_CTRL_WEN];
  assign abort_evt = (state_r == PFE_BUSY) && i_flash_abort;
  assign err_evt = abort_evt || (start_req && (req_invalid || req_protected));

  // control fields written by software
  // program enable only ever changes through software writes
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      region_r <= 2'(`PFE_CTRL_RST >> `PFE_CTRL_REG_LO);
      erase_sel_r <= 1'b0;
      program_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      region_r <= i_hwdata[`PFE_CTRL_REG_HI:`PFE_CTRL_REG_LO];
      erase_sel_r <= i_hwdata[`PFE_CTRL_ERASE];
      program_enable_r <= i_hwdata[`PFE_CTRL_WEN];
    end
  end

  // error flag: software may write it, an event set wins
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      program_error_r <= 1'b0;
    end else if (err_evt) begin
      program_error_r <= 1'b1;
    end else if (wr_ctrl) begin
      program_error_r <= i_hwdata[`PFE_CTRL_ERR];
    end
  end

  // table pointer, all 22 bits stored, low six unused by erase
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) table_pointer_r <= '0;
    else if (wr_ptr) table_pointer_r <= i_hwdata[`PFE_PTR_W-1:0];
  end

  // protection boundary and interrupt mask
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      prot_rows_r <= `PFE_PROT_RST;
      irq_mask_r <= `PFE_MASK_RST;
    end else begin
      if (wr_prot) prot_rows_r <= i_hwdata[15:0];
      if (wr_mask) irq_mask_r <= i_hwdata[1:0];
    end
  end

  // ---------------------------------------------------------
  // unlock sequence
  // ---------------------------------------------------------
  // key one then key two back to back arms one start;
  // any other register write disarms
  // the armed flag reads back at the unlock offset for software to confirm
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      key_one_r <= 1'b0;
      armed_r <= 1'b0;
    end else if (wr_unlock) begin
      key_one_r <= (i_hwdata[7:0] == `PFE_KEY_ONE);
      armed_r <= key_one_r && (i_hwdata[7:0] == `PFE_KEY_TWO);
    end else if (wr_pend_r) begin
      key_one_r <= 1'b0;
      armed_r <= 1'b0; // used or dropped by the next write
    end
  end

  // ---------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------
  // start bit reads as busy; hardware clears it at the end
  // the write operation shares the erase timer; the word data path
  // itself lives outside this block
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_r <= PFE_IDLE;
      op_r <= PFE_OP_WRITE;
      row_r <= '0;
    end else begin
      case (state_r)
        PFE_IDLE: begin
          if (launch) begin
            state_r <= PFE_BUSY;
            // erase-select picks erase, otherwise write
            op_r <= i_hwdata[`PFE_CTRL_ERASE] ? PFE_OP_ERASE : PFE_OP_WRITE;
            row_r <= req_row;
          end
        end
        PFE_BUSY: begin
          if (timer_done || abort_evt) state_r <= PFE_IDLE;
        end
        default: state_r <= PFE_IDLE;
      endcase
    end
  end

  pfe_timer #(
    .CYCLES(ERASE_CYCLES)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_start(launch),
    .i_abort(abort_evt),
    .o_busy(timer_busy),
    .o_done(timer_done)
  );

  // array strobes address a whole row, never a word
  assign o_flash_erase = (state_r == PFE_BUSY) && (op_r == PFE_OP_ERASE);
  assign o_flash_write = (state_r == PFE_BUSY) && (op_r == PFE_OP_WRITE);
  assign o_flash_row = row_r;
  // cpu halted for the whole long write
  assign o_cpu_stall = (state_r == PFE_BUSY);

  // ---------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------
  // sticky, write one to clear, set wins over clear
  // the error bit mirrors every error event, the done bit only completion
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      irq_stat_r <= 2'h0;
    end else begin
      irq_stat_r[`PFE_IRQ_DONE] <= timer_done
        || (irq_stat_r[`PFE_IRQ_DONE] && !(wr_stat && i_hwdata[`PFE_IRQ_DONE]));
      irq_stat_r[`PFE_IRQ_ERR] <= err_evt
        || (irq_stat_r[`PFE_IRQ_ERR] && !(wr_stat && i_hwdata[`PFE_IRQ_ERR]));
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

  // ---------------------------------------------------------
  // read mux
  // ---------------------------------------------------------
  logic [31:0] rd_mux; // value for the next data phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_haddr[7:0])
      `PFE_OFF_CTRL: begin
        rd_mux[`PFE_CTRL_REG_HI:`PFE_CTRL_REG_LO] = region_r;
        rd_mux[`PFE_CTRL_ERASE] = erase_sel_r;
        rd_mux[`PFE_CTRL_ERR] = program_error_r;
        rd_mux[`PFE_CTRL_WEN] = program_enable_r;
        rd_mux[`PFE_CTRL_START] = (state_r == PFE_BUSY);
      end
      `PFE_OFF_PTR: rd_mux[`PFE_PTR_W-1:0] = table_pointer_r;
      `PFE_OFF_UNLOCK: rd_mux[0] = armed_r;
      `PFE_OFF_STAT: rd_mux[1:0] = irq_stat_r;
      `PFE_OFF_MASK: rd_mux[1:0] = irq_mask_r;
      `PFE_OFF_PROT: rd_mux[15:0] = prot_rows_r;
      default: rd_mux = 32'h0000_0000; // unmapped reads zero
    endcase
  end

  // read data captured at the address phase
  // so hrdata comes straight from a flop during the data phase
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) rdata_r <= 32'h0000_0000;
    else if (addr_ok && !i_hwrite) rdata_r <= rd_mux;
  end

  // ---------------------------------------------------------
  // checks
  // ---------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // every property samples on the system clock and is quiet in reset;
  // the tag on each label line names the behaviour it guards

  row_select_a: assert property (launch |=> (o_flash_row == $past(table_pointer_r[21:6])))
    else $error("row not taken from pointer bits 21:6");
  erase_select_a: assert property (launch && i_hwdata[`PFE_CTRL_ERASE] |=> o_flash_erase && !o_flash_write)
    else $error("erase select did not start an erase");
  write_select_a: assert property (launch && !i_hwdata[`PFE_CTRL_ERASE] |=> o_flash_write && !o_flash_erase)
    else $error("cleared erase select did not start a write");
  stall_cover_a: assert property ((o_flash_erase || o_flash_write) |-> o_cpu_stall && timer_busy)
    else $error("cpu not stalled during long write");
  protect_skip_a: assert property (start_req && req_protected && state_r == PFE_IDLE
    |=> !o_cpu_stall && program_error_r && irq_stat_r[1])
    else $error("protected row was not refused");
  done_flag_a: assert property (timer_done |=> irq_stat_r[0] && !o_cpu_stall)
    else $error("completion did not set done flag");
  irq_gate_a: assert property (irq_stat_r[0] && !irq_mask_r[0] && !irq_stat_r[1] |-> !o_irq)
    else $error("interrupt raised without enable");
  enable_kept_a: assert property (!wr_ctrl |=> $stable(program_enable_r))
    else $error("program enable changed without a write");
  abort_err_a: assert property (abort_evt |=> program_error_r && state_r == PFE_IDLE)
    else $error("abort did not flag an error");
  invalid_err_a: assert property (start_req && req_invalid |=> program_error_r && !o_cpu_stall)
    else $error("invalid start did not flag an error");
  one_row_a: assert property (o_cpu_stall && $past(o_cpu_stall) |-> $stable(o_flash_row))
    else $error("row changed during a long write");
  // further guards on the sequencer and its flags
  timer_sync_a: assert property (o_cpu_stall == timer_busy)
    else $error("stall and erase timer out of step");
  start_hold_a: assert property (o_cpu_stall && !timer_done && !abort_evt |=> o_cpu_stall)
    else $error("stall dropped before the timer ended");
  start_clear_a: assert property (timer_done || abort_evt |=> !o_cpu_stall)
    else $error("start bit not cleared at the end");
  done_once_a: assert property (timer_done |=> !timer_done)
    else $error("completion pulse longer than one cycle");
  irq_follow_a: assert property (irq_stat_r[`PFE_IRQ_DONE] && irq_mask_r[`PFE_IRQ_DONE] |-> o_irq)
    else $error("enabled completion raised no interrupt");
  abort_no_done_a: assert property (abort_evt && !irq_stat_r[`PFE_IRQ_DONE] |=> !irq_stat_r[`PFE_IRQ_DONE])
    else $error("aborted long write reported done");
  err_sticky_a: assert property (program_error_r && !wr_ctrl |=> program_error_r)
    else $error("error flag dropped by hardware");
  row_range_a: assert property (o_cpu_stall |-> (32'(o_flash_row) < 32'(ROWS)))
    else $error("long write on a row outside the array");
  locked_start_a: assert property (start_req && !armed_r |=> !o_cpu_stall)
    else $error("start accepted without unlock");
  unlock_used_a: assert property (launch |=> !armed_r)
    else $error("unlock not consumed by the start");
endmodule : pfe_top
`default_nettype wire

// ### bench/pfe_flash_model.sv
// flash array model standing behind the row-erase sequencer
// assumes erase/write levels and the row from pfe_top on the system clock
`timescale 1ns/10ps
`default_nettype none
module pfe_flash_model (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_erase,
  input wire logic i_write,
  input wire logic [15:0] i_row,
  input wire logic i_abort_req,
  output logic o_abort,
  output logic o_row_moved
);
  logic [15:0] row_r; // row latched when the long write starts
  logic [3:0] age_r; // cycles into the long write
  // ----------------------------------------
  // one whole row per long write
  // ----------------------------------------
  // a row that moves mid-operation would touch a second row
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      age_r <= 4'h0;
      o_row_moved <= 1'b0;
    end else if (i_erase || i_write) begin
      if (age_r == 4'h0) row_r <= i_row;
      else if (row_r != i_row) o_row_moved <= 1'b1;
      age_r <= age_r + 4'h1;
    end else begin
      age_r <= 4'h0;
    end
  end
  // cut the long write short three cycles in, only when the bench asks
  assign o_abort = i_abort_req && (i_erase || i_write) && (age_r == 4'h3);
endmodule // pfe_flash_model
`default_nettype wire

// ### bench/program_flash_row_erase_tb.sv
// self-checking bench for the row-erase sequencer
// assumes pfe_top with a shortened erase timer and the flash model beside it
`timescale 1ns/10ps
`default_nettype none
`include "pfe_params.svh"
module program_flash_row_erase_tb;
  import pfe_pkg::*;
  localparam int ERASE_N = 8; // shortened erase timer
  logic clk_sys, srst, hsel, hwrite, abort_req, flash_abort, row_moved;
  logic [31:0] haddr, hwdata, hrdata, ptr, lfsr, rd;
  logic [1:0] htrans;
  logic hreadyout, hresp, flash_erase, flash_write, cpu_stall, irq;
  pfe_row_t flash_row;
  logic [7:0] ctl;
  int err_count, total_checks, n;
  pfe_top #(.ERASE_CYCLES(ERASE_N), .ROWS(256)) pfe_top_inst (
    .i_clk_sys(clk_sys), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .i_flash_abort(flash_abort), .o_flash_erase(flash_erase),
    .o_flash_write(flash_write), .o_flash_row(flash_row), .o_cpu_stall(cpu_stall), .o_irq(irq));
  pfe_flash_model pfe_flash_model_inst (
    .i_clk_sys(clk_sys), .i_srst(srst), .i_erase(flash_erase), .i_write(flash_write), .i_row(flash_row),
    .i_abort_req(abort_req), .o_abort(flash_abort), .o_row_moved(row_moved));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // control value after the op: start cleared, error added
  function automatic logic [31:0] exp_ctl(input logic [7:0] c, input logic e);
    return {24'h000000, (c & 8'hFD) | (e ? 8'h08 : 8'h00)};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single ahb-lite transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] q);
    int k;
    haddr <= {24'h000000, off};
    htrans <= 2'h2;
    hwrite <= w;
    k = 0;
    do begin @(posedge clk_sys); k++; end while (hreadyout !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk_sys); k++; end while (hreadyout !== 1'b1 && k < 100);
    q = hrdata;
    if (k >= 100) begin
      err_count++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, off, d, x);
  endtask
  task automatic rchk(input string nm, input logic [7:0] off, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, off, 32'h0, x);
    check(nm, x, exp);
  endtask
  // load pointer, optionally unlock, then write the control byte
  task automatic start(input logic [31:0] p, input logic [7:0] c, input logic unlock);
    wr(`PFE_OFF_PTR, p);
    if (unlock) begin
      wr(`PFE_OFF_UNLOCK, {24'h0, `PFE_KEY_ONE});
      wr(`PFE_OFF_UNLOCK, {24'h0, `PFE_KEY_TWO});
    end
    wr(`PFE_OFF_CTRL, {24'h000000, c});
    #1;
  endtask
  // count cycles of the cpu stall, bounded
  task automatic stall_len(output int m);
    m = 0;
    while (cpu_stall === 1'b1 && m < 100) begin @(posedge clk_sys); #1; m++; end
    @(posedge clk_sys);
    if (m >= 100) begin
      err_count++;
      results();
    end
  endtask
  task automatic results();
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    err_count++;
    results();
  end
  initial begin
    srst = 1'b1; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    abort_req = 1'b0; lfsr = 32'hF440; err_count = 0; total_checks = 0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    check("stall_rst", cpu_stall, 0);
    rchk("ctrl_rst", `PFE_OFF_CTRL, 0);
    rchk("stat_rst", `PFE_OFF_STAT, 0);
    rchk("mask_rst", `PFE_OFF_MASK, 0);
    wr(8'h18, 32'hFFFFFFFF); // unmapped write dropped
    rchk("unmapped", 8'h18, 0);
    // erases and writes, random rows, corner row 255 first, irq masked later
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      ptr = (i == 0) ? 32'h00003FFF : {18'h0, lfsr[13:0]};
      ctl = i[0] ? 8'h86 : 8'h96;
      wr(`PFE_OFF_MASK, (i < 2) ? 32'h3 : 32'h0);
      start(ptr, ctl, 1'b1);
      check("erase", flash_erase, !i[0]);
      check("write", flash_write, i[0]);
      check("row", flash_row, ptr[21:6]);
      stall_len(n);
      check("stall_len", n, ERASE_N);
      rchk("stat_done", `PFE_OFF_STAT, 1);
      check("irq", irq, (i < 2));
      rchk("ctrl_done", `PFE_OFF_CTRL, exp_ctl(ctl, 0));
      check("row_moved", row_moved, 0);
      wr(`PFE_OFF_STAT, 32'h3);
      rchk("stat_clr", `PFE_OFF_STAT, 0);
      check("irq_clr", irq, 0);
    end
    // no unlock, or program enable clear: start ignored
    start(32'h40, 8'h96, 1'b0);
    check("no_unlock", cpu_stall, 0);
    start(32'h40, 8'h92, 1'b1);
    check("no_wen", cpu_stall, 0);
    rchk("stat_quiet", `PFE_OFF_STAT, 0);
    // keys read back as armed until any other write lands
    wr(`PFE_OFF_UNLOCK, {24'h0, `PFE_KEY_ONE});
    wr(`PFE_OFF_UNLOCK, {24'h0, `PFE_KEY_TWO});
    rchk("armed", `PFE_OFF_UNLOCK, 1);
    wr(`PFE_OFF_PTR, 32'h3FC0);
    rchk("disarmed", `PFE_OFF_UNLOCK, 0);
    rchk("ptr_rd", `PFE_OFF_PTR, 32'h3FC0);
    // protected row just below the limit, bad region, row past the array
    wr(`PFE_OFF_MASK, 32'h2);
    wr(`PFE_OFF_PROT, 32'h10);
    rchk("prot_rd", `PFE_OFF_PROT, 32'h10);
    for (int j = 0; j < 3; j++) begin
      ptr = (j == 0) ? 32'h3FF : (j == 1) ? 32'h1000 : 32'h4000;
      ctl = (j == 1) ? 8'h56 : 8'h96;
      start(ptr, ctl, 1'b1);
      check("err_stall", cpu_stall, 0);
      rchk("err_ctrl", `PFE_OFF_CTRL, exp_ctl(ctl, 1));
      rchk("err_stat", `PFE_OFF_STAT, 2);
      check("err_irq", irq, 1);
      wr(`PFE_OFF_STAT, 32'h3);
      wr(`PFE_OFF_CTRL, 32'h0);
    end
    // abort three cycles into an erase
    wr(`PFE_OFF_PROT, 32'h0);
    abort_req <= 1'b1;
    start(32'h1C0, 8'h96, 1'b1);
    stall_len(n);
    abort_req <= 1'b0;
    check("abort_len", n, 4);
    rchk("abort_stat", `PFE_OFF_STAT, 2);
    rchk("abort_ctrl", `PFE_OFF_CTRL, exp_ctl(8'h96, 1));
    results();
  end
endmodule // program_flash_row_erase_tb
`default_nettype wire
